// ==== verilog/rwp_pkg.sv ====
/*
  Package for the reset and wake pin control block: state types, the
  carrier structs for the host strobes and the wake configuration, and
  the timing and reset constants.
  Assumes a single 40 MHz system clock and a synchronous reset.
*/
package rwp_pkg;

  // Reference and system clock rates in kHz.
  localparam int unsigned REF_CLK_KHZ     = 25000;
  localparam int unsigned SYS_CLK_KHZ     = 40000;

  // Reset values of the control state.
  localparam logic        RST_READ_SEEN   = 1'b0;
  localparam logic        RST_SLEEP       = 1'b0;
  localparam logic        RST_WAKE_EVENT  = 1'b0;
  localparam logic        RST_CROSSOVER   = 1'b1;

  // Field positions of the wake configuration carrier.
  localparam int unsigned WCFG_EN_POS     = 0;
  localparam int unsigned WCFG_POL_POS    = 1;
  localparam int unsigned WCFG_OD_POS     = 2;

  typedef enum logic [1:0]
  {
    RWP_IDLE,
    RWP_WRITE,
    RWP_READ
  } rwp_cycle_t;

  // Host strobes as seen on the pins, all active low.
  typedef struct packed
  {
    logic chip_select_low;
    logic write_strobe_low;
    logic read_strobe_low;
  } rwp_strobes_t;

  // Wake indicator configuration.
  typedef struct packed
  {
    logic open_drain;
    logic active_high;
    logic enable;
  } rwp_wake_cfg_t;

endpackage

// ==== verilog/rwp_sync.sv ====
/*
  Two flip-flop synchroniser for a group of pin levels.
  Assumes the inputs are asynchronous to CLK_SYS and that reset is
  synchronous and active high.
*/
`timescale 1ns/1ps
module rwp_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;

  always_comb
  begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= RST_VAL;
      q_reg    <= RST_VAL;
    end
    else
    begin
      meta_reg <= meta_next;
      q_reg    <= q_next;
    end
  end

  assign q = q_reg;

endmodule // rwp_sync

// ==== verilog/rwp_top.sv ====
/*
  Reset, wake indicator and strap logic of the controller's system pins.
  Tracks the read that must follow reset or wake, gates internal writes,
  leaves power saving on any host write and drives the wake indicator.
  Assumes CLK_SYS at 40 MHz is derived from the 25 MHz reference, and
  that SYS_RST is synchronous to it; the pins are synchronised here.
*/
`timescale 1ns/1ps

// How it works
// - Internal timing comes from the 40 MHz CLK_SYS input, derived from the 25 MHz reference.
// - Pin reset low returns all state to its reset value.
// - After reset or wake, writes stay blocked until one host read happens.
// - When enabled, a wake event during power saving asserts the wake indicator output.
// - Wake indicator polarity and push-pull or open-drain are programmable.
// - Wake events and the indicator never end power saving themselves.
// - Any host write, chip select and write strobe together, ends power saving.
// - Crossover detection follows the strap: high enables, low disables.
// - Chip select and write strobe are active low; both low is a write.
module rwp_top
  import rwp_pkg::*;
(
  // Clock and reset.
  input  wire logic                   CLK_SYS,
  input  wire logic                   SYS_RST,
  input  wire logic                   PIN_RESET_LOW,
  input  wire logic                   SOFT_RESET_BIT,
  // Host strobes from the pins.
  input  wire rwp_pkg::rwp_strobes_t  HOST_STROBES,
  // Power management.
  input  wire logic                   SLEEP_REQ,
  input  wire logic                   WAKE_EVENT,
  input  wire logic                   WAKE_CLEAR,
  input  wire rwp_pkg::rwp_wake_cfg_t WAKE_CFG,
  // Strap.
  input  wire logic                   CROSSOVER_AUTO_STRAP,
  // Status and control outputs.
  output logic                        LOGIC_RESET,
  output logic                        WRITE_ENABLE,
  output logic                        HOST_WRITE,
  output logic                        POWER_SAVING,
  output logic                        CROSSOVER_ENABLE,
  output logic                        WAKE_INDICATOR_OUT_O,
  output logic                        WAKE_INDICATOR_OUT_OE
);

  import rwp_pkg::*;

  localparam int unsigned CLK_RATIO_X1000 = (SYS_CLK_KHZ * 1000) / REF_CLK_KHZ;

  // Pins pass two flip-flops before any logic reads them.
  logic [4:0] pins_sync;
  logic       rst_pin_low_s;
  logic       cs_low_s;
  logic       wr_low_s;
  logic       rd_low_s;
  logic       strap_s;

  rwp_sync #(
    .WIDTH   (5),
    .RST_VAL (5'h1F)
  ) u_sync (
    .clk (CLK_SYS),
    .rst (SYS_RST),
    .d   ({PIN_RESET_LOW, HOST_STROBES.chip_select_low,
           HOST_STROBES.write_strobe_low, HOST_STROBES.read_strobe_low,
           CROSSOVER_AUTO_STRAP}),
    .q   (pins_sync)
  );

  assign rst_pin_low_s = pins_sync[4];
  assign cs_low_s      = pins_sync[3];
  assign wr_low_s      = pins_sync[2];
  assign rd_low_s      = pins_sync[1];
  assign strap_s       = pins_sync[0];

  // Any of the three reset sources clears the logic; the soft reset bit is on-chip.
  logic int_rst;
  assign int_rst = SYS_RST || !rst_pin_low_s || SOFT_RESET_BIT;

  // Strobe decode; a cycle is counted once, on its leading edge.
  rwp_cycle_t cycle_reg;
  rwp_cycle_t cycle_next;
  logic       write_start;
  logic       read_start;

  always_comb
  begin
    cycle_next  = cycle_reg;
    write_start = 1'b0;
    read_start  = 1'b0;
    case (cycle_reg)
      RWP_IDLE:
      begin
        if (!cs_low_s && !wr_low_s)
        begin
          cycle_next  = RWP_WRITE;
          write_start = 1'b1;
        end
        else if (!cs_low_s && !rd_low_s)
        begin
          cycle_next = RWP_READ;
          read_start = 1'b1;
        end
      end
      RWP_WRITE:
      begin
        if (cs_low_s || wr_low_s)
        begin
          cycle_next = RWP_IDLE;
        end
      end
      RWP_READ:
      begin
        if (cs_low_s || rd_low_s)
        begin
          cycle_next = RWP_IDLE;
        end
      end
      default:
      begin
        cycle_next = RWP_IDLE;
      end
    endcase
  end

  // Power state, read-seen flag and wake event.
  logic read_seen_reg;
  logic read_seen_next;
  logic sleep_reg;
  logic sleep_next;
  logic event_reg;
  logic event_next;
  logic host_write_reg;
  logic host_write_next;
  logic xover_reg;
  logic xover_next;

  always_comb
  begin
    read_seen_next  = read_seen_reg;
    sleep_next      = sleep_reg;
    event_next      = event_reg;
    host_write_next = 1'b0;
    xover_next      = strap_s;
    // The wake event sets but does not touch the power state.
    if (WAKE_CLEAR)
    begin
      event_next = 1'b0;
    end
    if (WAKE_EVENT && sleep_reg)
    begin
      event_next = 1'b1;
    end
    if (sleep_reg)
    begin
      if (write_start)
      begin
        // Any write wakes, whatever its data, and a read is needed again.
        sleep_next     = 1'b0;
        read_seen_next = 1'b0;
        event_next     = 1'b0;
      end
    end
    else
    begin
      if (SLEEP_REQ)
      begin
        sleep_next     = 1'b1;
        read_seen_next = 1'b0;
      end
      else if (read_start)
      begin
        read_seen_next = 1'b1;
      end
      else if (write_start && read_seen_reg)
      begin
        host_write_next = 1'b1;
      end
    end
  end

  // Wake pin: drive level or, in open-drain, drive only when the pin level is low.
  logic wake_active;
  logic pin_o_reg;
  logic pin_o_next;
  logic pin_oe_reg;
  logic pin_oe_next;

  always_comb
  begin
    wake_active = event_reg && WAKE_CFG.enable;
    pin_o_next  = WAKE_CFG.active_high ? wake_active : !wake_active;
    pin_oe_next = 1'b1;
    if (WAKE_CFG.open_drain)
    begin
      // Open-drain can only pull low, so it suits active-low use.
      pin_o_next  = 1'b0;
      pin_oe_next = WAKE_CFG.active_high ? !wake_active : wake_active;
    end
  end

  logic rst_out_reg;

  always_ff @(posedge CLK_SYS)
  begin
    rst_out_reg <= int_rst;
    if (int_rst)
    begin
      cycle_reg      <= RWP_IDLE;
      read_seen_reg  <= RST_READ_SEEN;
      sleep_reg      <= RST_SLEEP;
      event_reg      <= RST_WAKE_EVENT;
      host_write_reg <= 1'b0;
      xover_reg      <= RST_CROSSOVER;
      pin_o_reg      <= 1'b0;
      pin_oe_reg     <= 1'b0;
    end
    else
    begin
      cycle_reg      <= cycle_next;
      read_seen_reg  <= read_seen_next;
      sleep_reg      <= sleep_next;
      event_reg      <= event_next;
      host_write_reg <= host_write_next;
      xover_reg      <= xover_next;
      pin_o_reg      <= pin_o_next;
      pin_oe_reg     <= pin_oe_next;
    end
  end

  assign LOGIC_RESET           = rst_out_reg;
  assign WRITE_ENABLE          = read_seen_reg;
  assign HOST_WRITE            = host_write_reg;
  assign POWER_SAVING          = sleep_reg;
  assign CROSSOVER_ENABLE      = xover_reg;
  assign WAKE_INDICATOR_OUT_O  = pin_o_reg;
  assign WAKE_INDICATOR_OUT_OE = pin_oe_reg;

  // Clock ratio is fixed by the 25 MHz reference.
  initial
  begin
    a_clock_ratio : assert (CLK_RATIO_X1000 == 1600)
      else $error("system clock is not derived from the reference");
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);

  sequence s_write_in_sleep;
    sleep_reg && write_start && !int_rst;
  endsequence

  a_reset_clears : assert property (int_rst
                                    |=> !sleep_reg && !read_seen_reg && !event_reg)
    else $error("reset did not clear state");
  a_soft_reset : assert property (SOFT_RESET_BIT |=> LOGIC_RESET && !WRITE_ENABLE)
    else $error("soft reset bit ignored");
  a_write_gated : assert property (HOST_WRITE |-> $past(read_seen_reg))
    else $error("write passed before a read");
  a_read_unlocks : assert property (!int_rst && !sleep_reg && !SLEEP_REQ && read_start
                                    |=> WRITE_ENABLE)
    else $error("read did not unlock writes");
  a_wake_shows : assert property (!int_rst && event_reg && WAKE_CFG.enable
                                  && !WAKE_CFG.open_drain && WAKE_CFG.active_high
                                  && $stable(WAKE_CFG) |=> WAKE_INDICATOR_OUT_O)
    else $error("wake indicator not asserted");
  a_od_no_high : assert property (WAKE_INDICATOR_OUT_OE && $past(WAKE_CFG.open_drain)
                                  && !$past(int_rst) |-> !WAKE_INDICATOR_OUT_O)
    else $error("open-drain pin drove high");
  a_event_keeps : assert property (sleep_reg && !write_start && !int_rst |=> sleep_reg)
    else $error("left power saving without a write");
  a_write_wakes : assert property (s_write_in_sleep |=> !sleep_reg ##0 !read_seen_reg)
    else $error("host write did not wake");
  a_strap_follows : assert property (!int_rst |=> CROSSOVER_ENABLE == $past(strap_s))
    else $error("crossover does not follow strap");
  a_write_decode : assert property (HOST_WRITE
                                    |-> $past(!cs_low_s && !wr_low_s && cycle_reg == RWP_IDLE))
    else $error("write decoded without both strobes low");

endmodule // rwp_top

// ==== sim/rwp_host_model.sv ====
/*
  Host model: drives the active-low chip select and strobes.
  Assumes one calling process and inputs changed at the falling edge.
*/
`timescale 1ns/1ps
module rwp_host_model
  import rwp_pkg::*;
(
  // Clock and pins.
  input  wire logic             clk,
  output rwp_pkg::rwp_strobes_t stb
);
  initial stb = '1;

  // The wake write is meant for the test register; no address is modelled.
  task automatic access(input logic wr, input int hold);
    @(negedge clk);
    stb = {1'b0, ~wr, wr};
    repeat (hold) @(negedge clk);
    stb = '1;
    // Strobes stay high long enough for the next cycle to count.
    repeat (3) @(negedge clk);
  endtask
endmodule // rwp_host_model

// ==== sim/reset_wake_pin_control_tb_top.sv ====
/*
  Testbench for the reset and wake pin block, with a scoreboard queue.
  Assumes rwp_top and the host model are compiled first.
*/
`timescale 1ns/1ps
module reset_wake_pin_control_tb_top;
  import rwp_pkg::*;
  logic          clk, rst, prl, soft_reset_bit, slp, wev, wclr, strap;
  rwp_strobes_t  stb;
  rwp_wake_cfg_t cfg;
  logic          lrst, we, hw, ps, xen, po, poe, ps_prev, seen;
  logic [31:0]   rnd;
  int            err_total, n_compared, seed;
  logic [1:0]    exp_q[$];

  rwp_top u_rwp_top (.CLK_SYS(clk), .SYS_RST(rst), .PIN_RESET_LOW(prl),
    .SOFT_RESET_BIT(soft_reset_bit), .HOST_STROBES(stb), .SLEEP_REQ(slp), .WAKE_EVENT(wev),
    .WAKE_CLEAR(wclr), .WAKE_CFG(cfg), .CROSSOVER_AUTO_STRAP(strap), .LOGIC_RESET(lrst),
    .WRITE_ENABLE(we), .HOST_WRITE(hw), .POWER_SAVING(ps), .CROSSOVER_ENABLE(xen),
    .WAKE_INDICATOR_OUT_O(po), .WAKE_INDICATOR_OUT_OE(poe));
  rwp_host_model u_rwp_host_model (.clk(clk), .stb(stb));

  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Expected pin from the configuration; open drain only ever pulls low.
  task automatic pin(input logic act);
    logic lvl;
    lvl = (act & cfg.enable) ~^ cfg.active_high;
    chk("wake pin", cfg.open_drain ? {~lvl, 1'b0} : {1'b1, lvl}, {poe, po});
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Each accepted write or wake must match the oldest note.
  always @(negedge clk)
  begin
    if (hw === 1'b1 || (ps_prev === 1'b1 && ps === 1'b0))
      chk("host event", exp_q.size() ? exp_q.pop_front() : 2'h3, {hw, ps});
    ps_prev <= ps;
  end

  initial
  begin
    #(25 * 20000);
    err_total++;
    close_out();
  end

  initial
  begin
    seed = 32'h6fd9;
    {rst, prl, soft_reset_bit, slp, wev, wclr, strap} = 7'h61;
    cfg = '0;
    cyc(10);
    rst = 1'b0;
    cyc(4);
    chk("crossover", 2'h1, {1'b0, xen});
    u_rwp_host_model.access(1'b1, 3);
    chk("write enable", 2'h0, {1'b0, we});
    for (int k = 0; k < 3; k++)
    begin
      u_rwp_host_model.access(1'b0, 3);
      chk("write enable", 2'h1, {1'b0, we});
      exp_q.push_back(2'h2);
      u_rwp_host_model.access(1'b1, 3 + 3 * k);
      if (k == 2)
        break;
      // Soft reset first, pin reset second; both must block writes again.
      soft_reset_bit = (k == 0);
      prl = (k == 0);
      seen = 1'b0;
      repeat (6)
      begin
        cyc(1);
        soft_reset_bit = 1'b0;
        seen |= lrst;
      end
      prl = 1'b1;
      cyc(4);
      chk("reset pulse", 2'h1, {1'b0, seen});
      chk("write enable", 2'h0, {1'b0, we});
    end
    repeat (4)
    begin
      rnd = $random(seed);
      strap = rnd[0];
      cyc(4);
      chk("crossover", {1'b0, strap}, {1'b0, xen});
    end
    for (int i = 0; i < 8; i++)
    begin
      cfg = rwp_wake_cfg_t'(i[2:0]);
      slp = 1'b1;
      cyc(1);
      slp = 1'b0;
      cyc(3);
      chk("sleeping", 2'h1, {1'b0, ps});
      pin(1'b0);
      wev = 1'b1;
      cyc(1);
      wev = 1'b0;
      cyc(3);
      pin(1'b1);
      chk("still sleeping", 2'h1, {1'b0, ps});
      wclr = i[0];
      cyc(1);
      wclr = 1'b0;
      cyc(3);
      pin(~i[0]);
      exp_q.push_back(2'h0);
      u_rwp_host_model.access(1'b1, 3);
      pin(1'b0);
      chk("write enable", 2'h0, {1'b0, we});
      u_rwp_host_model.access(1'b0, 3);
    end
    chk("pending notes", 2'h0, 2'(exp_q.size()));
    close_out();
  end
endmodule // reset_wake_pin_control_tb_top
